// >>> hw/asm_monitor.sv
// Axis status monitor: capture, origin, current compare, drive flags
// What this block does
// - Capture done sets on trigger rise if armed
// - Capture latches free-running 32-bit microsecond time
// - Capture stores master feedback position
// - Capture stores commanded axis position
// - Capture stores axis feedback position
// - Zero request loads feedback into command
// - Zero request self-clears at zero following error
// - Motion flag means velocity command non-zero
// - Threshold flag while demand at least threshold
// - Clamp flag while demand at least clamp
// - Current clamped only while clamp enabled
// - Clamp enable resets inactive
// - Threshold and clamp in percent of rated
// - Origin strobe rise presets command, sets valid
// - Decel flag in last index decel segment
// - Decimal places zero to six, all distances
// - Load travel per whole motor revolutions
// - Recovery index uses own accel, decel, velocity
// - Power on mirrors bridge, drops on trip
// - No trip flag follows trip state
// - Axis ok ignores enable and travel limits
// - Enabled flag follows drive enable
`timescale 1ns/1ps
module asm_monitor #(
  parameter int NPIN = 5
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 traj_tick,
  input  wire logic                 capture_trigger_input,
  input  wire logic                 set_origin_strobe,
  input  wire logic                 bridge_closed,
  input  wire logic                 drive_trip,
  input  wire logic                 drive_enabled,
  input  wire logic                 axis_error,
  input  wire logic [31:0]          master_pos,
  input  wire logic [31:0]          cmd_pos,
  input  wire logic [31:0]          fb_pos,
  input  wire logic [31:0]          velocity_command_value,
  input  wire logic [15:0]          current_draw_percent,
  input  wire logic [1:0]           segment_code,
  input  wire logic                 last_index,
  output logic                      cmd_pos_load,
  output logic [31:0]               cmd_pos_load_value,
  output logic [15:0]               current_limited,
  output asm_pkg::asm_flags_t       flags,
  output logic [2:0]                distance_decimal_places,
  output logic [31:0]               load_travel_per_cycle,
  output logic [15:0]               motor_revs_per_cycle,
  output logic                      recovery_index_enable,
  output logic [31:0]               recovery_accel,
  output logic [31:0]               recovery_decel,
  output logic [31:0]               recovery_vel
);
  import asm_pkg::*;

  localparam logic [7:0] US_LAST = 8'(US_CYC - 1);

  // Pin synchroniser, three stages per pin
  logic [NPIN-1:0] s0_r;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] lvl_r;
  logic [NPIN-1:0] lvl_nxt;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] pins;

  // Control registers
  logic        cap_en_r,   cap_en_nxt;
  logic        clamp_en_r, clamp_en_nxt;
  logic        rec_en_r,   rec_en_nxt;
  logic [2:0]  dec_r,      dec_nxt;
  logic [15:0] thr_r,      thr_nxt;
  logic [15:0] clp_r,      clp_nxt;
  logic [31:0] preset_r,   preset_nxt;
  logic [31:0] travel_r,   travel_nxt;
  logic [15:0] revs_r,     revs_nxt;
  logic [31:0] racc_r,     racc_nxt;
  logic [31:0] rdec_r,     rdec_nxt;
  logic [31:0] rvel_r,     rvel_nxt;

  // Block state
  logic        zte_r,      zte_nxt;
  logic        ov_r,       ov_nxt;
  logic        done_r,     done_nxt;
  asm_cap_t    cap_r,      cap_nxt;
  logic [7:0]  div_r,      div_nxt;
  logic [31:0] us_r,       us_nxt;
  asm_flags_t  fl_r,       fl_nxt;
  logic        load_r,     load_nxt;
  logic [31:0] loadv_r,    loadv_nxt;
  logic [15:0] cur_r,      cur_nxt;

  // Bus slave state
  logic        awok_r,     awok_nxt;
  logic [7:0]  awa_r,      awa_nxt;
  logic        wok_r,      wok_nxt;
  logic [31:0] wd_r,       wd_nxt;
  logic [3:0]  ws_r,       ws_nxt;
  logic        bv_r,       bv_nxt;
  logic [1:0]  br_r,       br_nxt;
  logic        rv_r,       rv_nxt;
  logic [1:0]  rr_r,       rr_nxt;
  logic [31:0] rd_r,       rd_nxt;

  logic        do_wr;
  logic        wr_ctrl;
  logic [31:0] ctrl_new;
  logic        ok_rd;
  logic [31:0] rmux;
  logic        ok_wr;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign pins = {drive_enabled, drive_trip, bridge_closed, set_origin_strobe,
                 capture_trigger_input};

  // A level changes once the second and third stages agree
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      lvl_nxt[i] = (s1_r[i] == s2_r[i]) ? s2_r[i] : lvl_r[i];
      rise[i]    = lvl_nxt[i] & ~lvl_r[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s0_r  <= '0;
      s1_r  <= '0;
      s2_r  <= '0;
      lvl_r <= '0;
    end else begin
      s0_r  <= pins;
      s1_r  <= s0_r;
      s2_r  <= s1_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Read multiplexer
  always_comb begin
    ok_rd = 1'b1;
    rmux  = '0;
    case ({s_axi_araddr[7:2], 2'h0})
      OFS_CTRL: begin
        rmux[CB_CAP_EN]             = cap_en_r;
        rmux[CB_ZTE]                = zte_r;
        rmux[CB_CLAMP_EN]           = clamp_en_r;
        rmux[CB_REC_EN]             = rec_en_r;
        rmux[CB_DEC_HI:CB_DEC_LO]   = dec_r;
      end
      OFS_STATUS:  rmux[$bits(asm_flags_t)-1:0] = fl_r;
      OFS_THRESH:  rmux[15:0] = thr_r;
      OFS_CLAMP:   rmux[15:0] = clp_r;
      OFS_PRESET:  rmux = preset_r;
      OFS_TIME:    rmux = cap_r.stamp;
      OFS_LMASTER: rmux = cap_r.master;
      OFS_LCMD:    rmux = cap_r.cmd;
      OFS_LFB:     rmux = cap_r.fb;
      OFS_CURRENT: rmux[15:0] = cur_r;
      OFS_TRAVEL:  rmux = travel_r;
      OFS_REVS:    rmux[15:0] = revs_r;
      OFS_RACC:    rmux = racc_r;
      OFS_RDEC:    rmux = rdec_r;
      OFS_RVEL:    rmux = rvel_r;
      OFS_USCNT:   rmux = us_r;
      default:     ok_rd = 1'b0;
    endcase
  end

  // Write decode; read-only words accept and ignore a write
  always_comb begin
    case (awa_r)
      OFS_CTRL, OFS_STATUS, OFS_THRESH, OFS_CLAMP, OFS_PRESET, OFS_TIME,
      OFS_LMASTER, OFS_LCMD, OFS_LFB, OFS_CURRENT, OFS_TRAVEL, OFS_REVS,
      OFS_RACC, OFS_RDEC, OFS_RVEL, OFS_USCNT: ok_wr = 1'b1;
      default: ok_wr = 1'b0;
    endcase
  end

  assign do_wr    = awok_r & wok_r;
  assign wr_ctrl  = do_wr & (awa_r == OFS_CTRL) & ws_r[0];
  assign ctrl_new = merge('0, wd_r, ws_r);

  // Bus handshake
  always_comb begin
    awok_nxt = awok_r;
    awa_nxt  = awa_r;
    wok_nxt  = wok_r;
    wd_nxt   = wd_r;
    ws_nxt   = ws_r;
    bv_nxt   = bv_r;
    br_nxt   = br_r;
    rv_nxt   = rv_r;
    rr_nxt   = rr_r;
    rd_nxt   = rd_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awok_nxt = 1'b1;
      awa_nxt  = {s_axi_awaddr[7:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wok_nxt = 1'b1;
      wd_nxt  = s_axi_wdata;
      ws_nxt  = s_axi_wstrb;
    end
    if (do_wr) begin
      awok_nxt = 1'b0;
      wok_nxt  = 1'b0;
      bv_nxt   = 1'b1;
      br_nxt   = ok_wr ? RESP_OK : RESP_ERR;
    end else if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = ok_rd ? RESP_OK : RESP_ERR;
      rd_nxt = rmux;
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
  end

  assign s_axi_awready = ~awok_r & ~bv_r;
  assign s_axi_wready  = ~wok_r & ~bv_r;
  assign s_axi_arready = ~rv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rresp   = rr_r;
  assign s_axi_rdata   = rd_r;

  // Configuration registers
  always_comb begin
    cap_en_nxt   = cap_en_r;
    clamp_en_nxt = clamp_en_r;
    rec_en_nxt   = rec_en_r;
    dec_nxt      = dec_r;
    thr_nxt      = thr_r;
    clp_nxt      = clp_r;
    preset_nxt   = preset_r;
    travel_nxt   = travel_r;
    revs_nxt     = revs_r;
    racc_nxt     = racc_r;
    rdec_nxt     = rdec_r;
    rvel_nxt     = rvel_r;
    if (wr_ctrl) begin
      cap_en_nxt   = ctrl_new[CB_CAP_EN];
      clamp_en_nxt = ctrl_new[CB_CLAMP_EN];
      rec_en_nxt   = ctrl_new[CB_REC_EN];
    end
    if (do_wr && awa_r == OFS_CTRL && ws_r[1]) begin
      dec_nxt = (ctrl_new[CB_DEC_HI:CB_DEC_LO] > DEC_MAX) ? DEC_MAX
              : ctrl_new[CB_DEC_HI:CB_DEC_LO];
    end
    if (do_wr) begin
      case (awa_r)
        OFS_THRESH: thr_nxt    = 16'(merge({16'h0, thr_r}, wd_r, ws_r));
        OFS_CLAMP:  clp_nxt    = 16'(merge({16'h0, clp_r}, wd_r, ws_r));
        OFS_PRESET: preset_nxt = merge(preset_r, wd_r, ws_r);
        OFS_TRAVEL: travel_nxt = merge(travel_r, wd_r, ws_r);
        OFS_REVS:   revs_nxt   = 16'(merge({16'h0, revs_r}, wd_r, ws_r));
        OFS_RACC:   racc_nxt   = merge(racc_r, wd_r, ws_r);
        OFS_RDEC:   rdec_nxt   = merge(rdec_r, wd_r, ws_r);
        OFS_RVEL:   rvel_nxt   = merge(rvel_r, wd_r, ws_r);
        default: begin
        end
      endcase
    end
  end

  // Capture, origin, tracking error and flags
  always_comb begin
    zte_nxt   = zte_r;
    ov_nxt    = ov_r;
    done_nxt  = done_r;
    cap_nxt   = cap_r;
    div_nxt   = div_r + 8'h01;
    us_nxt    = us_r;
    fl_nxt    = fl_r;
    load_nxt  = 1'b0;
    loadv_nxt = loadv_r;
    cur_nxt   = cur_r;
    if (div_r == US_LAST) begin
      div_nxt = 8'h00;
      us_nxt  = us_r + 32'h1;
    end
    // Re-arm by software or by dropping the enable
    if (!cap_en_r || (wr_ctrl && ctrl_new[CB_CAP_RST])) begin
      done_nxt = 1'b0;
    end
    if (cap_en_r && !done_r && rise[0]) begin
      done_nxt      = 1'b1;
      cap_nxt.stamp = us_r;
      cap_nxt.master = master_pos;
      cap_nxt.cmd   = cmd_pos;
      cap_nxt.fb    = fb_pos;
    end
    if (traj_tick) begin
      if (zte_r && cmd_pos == fb_pos) begin
        zte_nxt = 1'b0;
      end else if (zte_r) begin
        load_nxt  = 1'b1;
        loadv_nxt = fb_pos;
      end
      fl_nxt.motion  = velocity_command_value != 32'h0;
      fl_nxt.thresh  = current_draw_percent >= thr_r;
      fl_nxt.clamp   = current_draw_percent >= clp_r;
      fl_nxt.decel   = (segment_code == SEG_DECEL) && last_index;
      fl_nxt.pwr_on  = lvl_r[2] & ~lvl_r[3];
      fl_nxt.no_trip = ~lvl_r[3];
      fl_nxt.axis_ok = ~axis_error & ~lvl_r[3];
      fl_nxt.pwr_en  = lvl_r[4];
      cur_nxt = (clamp_en_r && current_draw_percent > clp_r) ? clp_r
              : current_draw_percent;
    end
    if (wr_ctrl && ctrl_new[CB_OV_CLR]) begin
      ov_nxt = 1'b0;
    end
    if (wr_ctrl && ctrl_new[CB_ZTE]) begin
      zte_nxt = 1'b1;
    end
    // Origin preset wins over a tracking error load in the same cycle
    if (rise[1]) begin
      ov_nxt    = 1'b1;
      load_nxt  = 1'b1;
      loadv_nxt = preset_r;
    end
    fl_nxt.zte_req      = zte_nxt;
    fl_nxt.origin_valid = ov_nxt;
    fl_nxt.cap_done     = done_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_en_r   <= 1'b0;
      clamp_en_r <= 1'b0;
      rec_en_r   <= 1'b0;
      dec_r      <= DEC_RST;
      thr_r      <= THRESH_RST;
      clp_r      <= CLAMP_RST;
      preset_r   <= '0;
      travel_r   <= TRAVEL_RST;
      revs_r     <= REVS_RST;
      racc_r     <= '0;
      rdec_r     <= '0;
      rvel_r     <= '0;
      zte_r      <= 1'b0;
      ov_r       <= 1'b0;
      done_r     <= 1'b0;
      cap_r      <= '0;
      div_r      <= '0;
      us_r       <= '0;
      fl_r       <= '0;
      load_r     <= 1'b0;
      loadv_r    <= '0;
      cur_r      <= '0;
      awok_r     <= 1'b0;
      awa_r      <= '0;
      wok_r      <= 1'b0;
      wd_r       <= '0;
      ws_r       <= '0;
      bv_r       <= 1'b0;
      br_r       <= RESP_OK;
      rv_r       <= 1'b0;
      rr_r       <= RESP_OK;
      rd_r       <= '0;
    end else begin
      cap_en_r   <= cap_en_nxt;
      clamp_en_r <= clamp_en_nxt;
      rec_en_r   <= rec_en_nxt;
      dec_r      <= dec_nxt;
      thr_r      <= thr_nxt;
      clp_r      <= clp_nxt;
      preset_r   <= preset_nxt;
      travel_r   <= travel_nxt;
      revs_r     <= revs_nxt;
      racc_r     <= racc_nxt;
      rdec_r     <= rdec_nxt;
      rvel_r     <= rvel_nxt;
      zte_r      <= zte_nxt;
      ov_r       <= ov_nxt;
      done_r     <= done_nxt;
      cap_r      <= cap_nxt;
      div_r      <= div_nxt;
      us_r       <= us_nxt;
      fl_r       <= fl_nxt;
      load_r     <= load_nxt;
      loadv_r    <= loadv_nxt;
      cur_r      <= cur_nxt;
      awok_r     <= awok_nxt;
      awa_r      <= awa_nxt;
      wok_r      <= wok_nxt;
      wd_r       <= wd_nxt;
      ws_r       <= ws_nxt;
      bv_r       <= bv_nxt;
      br_r       <= br_nxt;
      rv_r       <= rv_nxt;
      rr_r       <= rr_nxt;
      rd_r       <= rd_nxt;
    end
  end

  assign cmd_pos_load            = load_r;
  assign cmd_pos_load_value      = loadv_r;
  assign current_limited         = cur_r;
  assign flags                   = fl_r;
  assign distance_decimal_places = dec_r;
  assign load_travel_per_cycle   = travel_r;
  assign motor_revs_per_cycle    = revs_r;
  assign recovery_index_enable   = rec_en_r;
  assign recovery_accel          = racc_r;
  assign recovery_decel          = rdec_r;
  assign recovery_vel            = rvel_r;
endmodule

// >>> shared/asm_pkg.sv
// Constants and carrier types for the axis status monitor
package asm_pkg;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_THRESH  = 8'h08;
  localparam logic [7:0] OFS_CLAMP   = 8'h0c;
  localparam logic [7:0] OFS_PRESET  = 8'h10;
  localparam logic [7:0] OFS_TIME    = 8'h14;
  localparam logic [7:0] OFS_LMASTER = 8'h18;
  localparam logic [7:0] OFS_LCMD    = 8'h1c;
  localparam logic [7:0] OFS_LFB     = 8'h20;
  localparam logic [7:0] OFS_CURRENT = 8'h24;
  localparam logic [7:0] OFS_TRAVEL  = 8'h28;
  localparam logic [7:0] OFS_REVS    = 8'h2c;
  localparam logic [7:0] OFS_RACC    = 8'h30;
  localparam logic [7:0] OFS_RDEC    = 8'h34;
  localparam logic [7:0] OFS_RVEL    = 8'h38;
  localparam logic [7:0] OFS_USCNT   = 8'h3c;

  localparam int CB_CAP_EN   = 0;
  localparam int CB_CAP_RST  = 1;
  localparam int CB_ZTE      = 2;
  localparam int CB_CLAMP_EN = 3;
  localparam int CB_REC_EN   = 4;
  localparam int CB_OV_CLR   = 5;
  localparam int CB_DEC_LO   = 8;
  localparam int CB_DEC_HI   = 10;

  localparam logic [15:0] THRESH_RST = 16'h0064;
  localparam logic [15:0] CLAMP_RST  = 16'h0064;
  localparam logic [15:0] REVS_RST   = 16'h0001;
  localparam logic [31:0] TRAVEL_RST = 32'h0000_0001;
  localparam logic [2:0]  DEC_RST    = 3'h0;
  localparam logic [2:0]  DEC_MAX    = 3'h6;
  localparam logic [15:0] PCT_RATED  = 16'h0064;

  localparam int CLK_NS = 5;
  localparam int US_NS  = 1000;
  localparam int US_CYC = US_NS / CLK_NS;

  localparam logic [1:0] SEG_DECEL = 2'h3;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef struct packed {
    logic zte_req;
    logic origin_valid;
    logic cap_done;
    logic pwr_en;
    logic axis_ok;
    logic no_trip;
    logic pwr_on;
    logic decel;
    logic clamp;
    logic thresh;
    logic motion;
  } asm_flags_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [31:0] master;
    logic [31:0] cmd;
    logic [31:0] fb;
  } asm_cap_t;
endpackage

// >>> verif/asm_monitor_properties.sv
// Concurrent checks on the axis status monitor ports
`timescale 1ns/1ps
module asm_monitor_properties (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                traj_tick,
  input wire logic                axis_error,
  input wire logic [31:0]         velocity_command_value,
  input wire logic [15:0]         current_draw_percent,
  input wire logic [1:0]          segment_code,
  input wire logic                last_index,
  input wire logic                cmd_pos_load,
  input wire logic [15:0]         current_limited,
  input wire asm_pkg::asm_flags_t flags
);
  import asm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_motion_flag: assert property (traj_tick |=>
      flags.motion == ($past(velocity_command_value) != 32'h0))
    else $error("motion flag wrong after tick");
  a_flags_hold: assert property (!traj_tick |=> $stable(flags[7:0]))
    else $error("tick flags changed without tick");
  a_decel_flag: assert property (traj_tick |=>
      flags.decel == ($past(segment_code) == SEG_DECEL && $past(last_index)))
    else $error("decel flag wrong after tick");
  a_axis_ok: assert property (traj_tick && axis_error |=> !flags.axis_ok)
    else $error("axis ok set during error");
  a_trip_gate: assert property (flags.pwr_on || flags.axis_ok |-> flags.no_trip)
    else $error("power or ok flag set while tripped");
  a_origin_load: assert property ($rose(flags.origin_valid) |-> cmd_pos_load)
    else $error("origin valid without position load");
  a_limit_bound: assert property (traj_tick |=>
      current_limited <= $past(current_draw_percent))
    else $error("limited current above demand");
  a_limit_pass: assert property (traj_tick ##1 !flags.clamp |->
      current_limited == $past(current_draw_percent))
    else $error("demand below clamp was altered");
endmodule

bind asm_monitor asm_monitor_properties asm_monitor_properties_i (.clk, .rst, .traj_tick,
  .axis_error, .velocity_command_value, .current_draw_percent, .segment_code, .last_index,
  .cmd_pos_load, .current_limited, .flags);

// >>> verif/asm_drive_model.sv
// Behavioural drive power stage and command position holder
`timescale 1ns/1ps
module asm_drive_model #(
  parameter int TICK_DIV = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_pos_load,
  input  wire logic [31:0] cmd_pos_load_value,
  input  wire logic        bridge_req,
  input  wire logic        trip_req,
  input  wire logic        enable_req,
  output logic             traj_tick = 1'h0,
  output logic             bridge_closed = 1'h0,
  output logic             drive_trip = 1'h0,
  output logic             drive_enabled = 1'h0,
  output logic [31:0]      cmd_pos = 32'h0
);
  int cnt = 0;
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      traj_tick <= 1'h0;
      cmd_pos <= 32'h0;
    end else begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      traj_tick <= (cnt == TICK_DIV - 1);
      if (cmd_pos_load) cmd_pos <= cmd_pos_load_value;
    end
    bridge_closed <= bridge_req && !trip_req;
    drive_trip <= trip_req;
    drive_enabled <= enable_req;
  end
endmodule

// >>> verif/axis_status_monitor_test.sv
// Self-checking bench for the axis status monitor
`timescale 1ns/1ps
module axis_status_monitor_test;
  import asm_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, master_pos = 32'h0, fb_pos = 32'h0;
  logic [31:0] velocity_command_value = 32'h0, ctl = 32'h0, rd_d, t;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, capture_trigger_input = 1'h0;
  logic set_origin_strobe = 1'h0, axis_error = 1'h0, last_index = 1'h0;
  logic bridge_req = 1'h0, trip_req = 1'h0, enable_req = 1'h0;
  logic [15:0] current_draw_percent = 16'h0;
  logic [1:0] segment_code = 2'h0, s_axi_bresp, s_axi_rresp, rd_r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic traj_tick, bridge_closed, drive_trip, drive_enabled, cmd_pos_load;
  logic recovery_index_enable;
  logic [31:0] s_axi_rdata, cmd_pos, cmd_pos_load_value, load_travel_per_cycle;
  logic [31:0] recovery_accel, recovery_decel, recovery_vel;
  logic [15:0] motor_revs_per_cycle, current_limited;
  logic [2:0] distance_decimal_places;
  asm_flags_t flags;
  int err_count = 0;
  int checked = 0;

  asm_monitor asm_monitor_i (.*);
  asm_drive_model #(.TICK_DIV(8)) asm_drive_model_i (.*);

  initial begin
    forever #2.5 clk = ~clk;
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task lim(input int n);
    if (n >= 400) begin
      err_count++;
      stop_test;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ra, rw, b;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    b = 1'h0;
    while (!b && n < 400) begin
      #1;
      ra = s_axi_awvalid && s_axi_awready;
      rw = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ra) s_axi_awvalid <= 1'h0;
      if (rw) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    lim(n);
    chk(r, er);
  endtask

  task rd(input logic [7:0] a);
    int n;
    logic ra, v;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    v = 1'h0;
    while (!v && n < 400) begin
      #1;
      ra = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge clk);
      if (ra) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    lim(n);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_d, e);
  endtask

  task tk;
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (!traj_tick && n < 400);
      lim(n);
    end
    @(posedge clk);
    #1;
  endtask

  task wfl(input int k, input logic v);
    int n;
    n = 0;
    while (flags[k] !== v && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    lim(n);
  endtask

  task t_reset;
    rc(OFS_CTRL, 32'h0);
    rc(OFS_THRESH, {16'h0, PCT_RATED});
    rc(OFS_CLAMP, {16'h0, PCT_RATED});
    rc(OFS_TRAVEL, 32'h1);
    rc(OFS_REVS, 32'h1);
    rd(8'h40);
    chk(rd_r, RESP_ERR);
    wr(8'h40, 32'h1, RESP_ERR);
  endtask

  task t_config;
    for (int v = 0; v < 8; v++) begin
      wr(OFS_CTRL, ctl | (32'(v) << 8), RESP_OK);
      #1;
      chk(distance_decimal_places, v > 6 ? 3'h6 : 3'(v));
    end
    wr(OFS_RACC, 32'h11, RESP_OK);
    wr(OFS_RDEC, 32'h22, RESP_OK);
    wr(OFS_RVEL, 32'h33, RESP_OK);
    wr(OFS_TRAVEL, 32'h1f4, RESP_OK);
    wr(OFS_REVS, 32'h3, RESP_OK);
    wr(OFS_CTRL, ctl | 32'h10, RESP_OK);
    #1;
    chk({recovery_index_enable, recovery_accel[7:0], recovery_decel[7:0], recovery_vel[7:0]},
        {1'h1, 24'h112233});
    chk({load_travel_per_cycle[15:0], motor_revs_per_cycle}, 32'h01f4_0003);
  endtask

  task t_current;
    logic [15:0] d[5] = '{16'h31, 16'h32, 16'h4f, 16'h50, 16'hc8};
    wr(OFS_THRESH, 32'h32, RESP_OK);
    wr(OFS_CLAMP, 32'h50, RESP_OK);
    foreach (d[i]) begin
      @(posedge clk);
      current_draw_percent <= d[i];
      tk;
      chk(flags.thresh, d[i] >= 16'h32);
      chk(flags.clamp, d[i] >= 16'h50);
      chk(current_limited, d[i]);
    end
    ctl[CB_CLAMP_EN] = 1'h1;
    wr(OFS_CTRL, ctl, RESP_OK);
    tk;
    chk(current_limited, 16'h50);
    rc(OFS_CURRENT, 32'h50);
    current_draw_percent <= 16'h31;
    tk;
    chk({flags.thresh, flags.clamp, current_limited}, {2'h0, 16'h31});
  endtask

  task t_motion;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      velocity_command_value <= i[0] ? 32'h8000_0000 : 32'h0;
      segment_code <= i[1:0];
      last_index <= i[2];
      tk;
      chk(flags.motion, i[0]);
      chk(flags.decel, i[2] && i[1:0] == SEG_DECEL);
    end
  endtask

  task t_drive;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      bridge_req <= i[0];
      trip_req <= i[1];
      enable_req <= i[2];
      axis_error <= i[3];
      tk;
      chk(flags.pwr_on, i[0] && !i[1]);
      chk(flags.no_trip, !i[1]);
      chk(flags.axis_ok, !i[3] && !i[1]);
      chk(flags.pwr_en, i[2]);
    end
    @(posedge clk);
    trip_req <= 1'h0;
    axis_error <= 1'h0;
  endtask

  task t_zero_origin;
    fb_pos <= 32'h28;
    wr(OFS_CTRL, ctl | 32'h4, RESP_OK);
    #1;
    chk(flags.zte_req, 1'h1);
    wfl(10, 1'h0);
    chk(cmd_pos, 32'h28);
    wr(OFS_PRESET, 32'h1234_5678, RESP_OK);
    set_origin_strobe <= 1'h1;
    #1;
    wfl(9, 1'h1);
    @(posedge clk);
    set_origin_strobe <= 1'h0;
    #1;
    chk(cmd_pos, 32'h1234_5678);
    wr(OFS_CTRL, ctl | 32'h20, RESP_OK);
    #1;
    chk(flags.origin_valid, 1'h0);
  endtask

  task t_capture;
    @(posedge clk);
    master_pos <= 32'ha5a5_0001;
    fb_pos <= 32'h5a5a_0002;
    ctl[CB_CAP_EN] = 1'h1;
    wr(OFS_CTRL, ctl, RESP_OK);
    capture_trigger_input <= 1'h1;
    #1;
    wfl(8, 1'h1);
    rc(OFS_LMASTER, 32'ha5a5_0001);
    rc(OFS_LCMD, cmd_pos);
    rc(OFS_LFB, 32'h5a5a_0002);
    rd(OFS_TIME);
    t = rd_d;
    rd(OFS_USCNT);
    chk(rd_d - t <= 32'h1, 1'h1);
    capture_trigger_input <= 1'h0;
    master_pos <= 32'h1;
    repeat (8) @(posedge clk);
    capture_trigger_input <= 1'h1;
    repeat (8) @(posedge clk);
    rc(OFS_LMASTER, 32'ha5a5_0001);
    wr(OFS_CTRL, ctl | 32'h2, RESP_OK);
    #1;
    chk(flags.cap_done, 1'h0);
    ctl[CB_CAP_EN] = 1'h0;
    wr(OFS_CTRL, ctl, RESP_OK);
    capture_trigger_input <= 1'h0;
    repeat (8) @(posedge clk);
    capture_trigger_input <= 1'h1;
    repeat (8) @(posedge clk);
    #1;
    chk(flags.cap_done, 1'h0);
    rc(OFS_LMASTER, 32'ha5a5_0001);
    capture_trigger_input <= 1'h0;
  endtask

  initial begin
    #400000;
    err_count++;
    stop_test;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    $display("reset test done");
    t_config;
    $display("config test done");
    t_current;
    $display("current test done");
    t_motion;
    $display("motion test done");
    t_drive;
    $display("drive test done");
    t_zero_origin;
    $display("position test done");
    t_capture;
    $display("capture test done");
    stop_test;
  end
endmodule
